// ### rtl/onchip_memory_map_decoder.sv
// Purpose: On-chip memory map decode, block aliasing, GPIO direction and external data path
// Assumes: Core drives program and data requests on REF_CLK; map controls are core-clocked
// Notes:   Region decode is combinational so a map change acts in its own cycle
//
// Overview of operation
// - With boot ROM enabled, program 0000-00FF outside 0040h-0043h reads the boot ROM.
// - Program 0040h-0043h is reserved: writes dropped, reads return zero.
// - Map select high: program FE00h-FEFFh and FF00h-FFFFh both hit block zero.
// - Map select low: data 0100h-01FFh and 0200h-02FFh both hit block zero.
// - Data 0300h-03FFh and 0400h-04FFh always hit block one.
// - All GPIO pins come out of reset as inputs, drivers off.
// - External data path is sixteen bits, one line per bit position.
`timescale 1ns/1ps
`include "memmap_map.svh"

module onchip_memory_map_decoder
	import memmap_pkg::*;
(
	input  wire logic                      REF_CLK,
	input  wire logic                      RESET_N,
	input  wire core_req_t                 PROG_REQ,
	input  wire core_req_t                 DATA_REQ,
	input  wire logic                      BOOT_ROM_ENABLE,
	input  wire logic                      BLOCK_ZERO_MAP_SELECT,
	input  wire logic [`MM_WORD_W-1:0]     BOOT_ROM_DATA,
	output logic      [`MM_WORD_W-1:0]     PROG_RDATA,
	output logic      [`MM_WORD_W-1:0]     DATA_RDATA,
	output region_t                        PROG_REGION,
	output region_t                        DATA_REGION,
	output logic                           BOOT_ROM_SEL,
	input  wire logic                      GPIO_CFG_WR,
	input  wire logic [`MM_GPIO_COUNT-1:0] GPIO_DIR_WDATA,
	input  wire logic [`MM_GPIO_COUNT-1:0] GPIO_OUT_WDATA,
	input  wire logic [`MM_GPIO_COUNT-1:0] GPIO_PIN_IN,
	output logic      [`MM_GPIO_COUNT-1:0] GPIO_PIN_OUT,
	output logic      [`MM_GPIO_COUNT-1:0] GPIO_PIN_OE,
	output logic      [`MM_GPIO_COUNT-1:0] GPIO_LEVEL,
	input  wire logic [`MM_WORD_W-1:0]     EXT_DATA_IN,
	output logic      [`MM_WORD_W-1:0]     EXT_DATA_OUT,
	output logic      [`MM_WORD_W-1:0]     EXT_DATA_OE,
	output logic                           EXT_WR_STROBE
);

	////////////////////////////////////////////////////////////////////////////////
	// Region decode

	dec_state_t            s_q;
	dec_state_t            s_d;
	region_t               prog_region;
	region_t               data_region;
	logic                  blk0_we;
	logic [`MM_BLK_AW-1:0] blk0_addr;
	logic [`MM_WORD_W-1:0] blk0_wdata;
	logic [`MM_WORD_W-1:0] blk0_rdata;
	logic                  blk1_we;
	logic [`MM_WORD_W-1:0] blk1_rdata;
	logic                  prog_ext_wr;
	logic                  data_ext_wr;

	function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
		input logic [15:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	always_comb begin
		if (in_range(PROG_REQ.addr, `MM_RSVD_LO, `MM_RSVD_HI)) begin
			prog_region = REG_RESERVED;
		end else if (BOOT_ROM_ENABLE && in_range(PROG_REQ.addr, `MM_BOOT_LO, `MM_BOOT_HI)) begin
			prog_region = REG_BOOT;
		end else if (BLOCK_ZERO_MAP_SELECT
			&& in_range(PROG_REQ.addr, `MM_P_BLK0_LO, `MM_P_BLK0_HI)) begin
			prog_region = REG_BLK_ZERO;
		end else begin
			prog_region = REG_OTHER;
		end
	end

	always_comb begin
		if (!BLOCK_ZERO_MAP_SELECT && in_range(DATA_REQ.addr, `MM_D_BLK0_LO, `MM_D_BLK0_HI)) begin
			data_region = REG_BLK_ZERO;
		end else if (in_range(DATA_REQ.addr, `MM_D_BLK1_LO, `MM_D_BLK1_HI)) begin
			data_region = REG_BLK_ONE;
		end else begin
			data_region = REG_OTHER;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Block RAM ports; low address byte folds both aliases onto one word

	always_comb begin
		if (BLOCK_ZERO_MAP_SELECT) begin
			blk0_we    = PROG_REQ.wr && (prog_region == REG_BLK_ZERO);
			blk0_addr  = PROG_REQ.addr[`MM_BLK_AW-1:0];
			blk0_wdata = PROG_REQ.wdata;
		end else begin
			blk0_we    = DATA_REQ.wr && (data_region == REG_BLK_ZERO);
			blk0_addr  = DATA_REQ.addr[`MM_BLK_AW-1:0];
			blk0_wdata = DATA_REQ.wdata;
		end
	end

	assign blk1_we = DATA_REQ.wr && (data_region == REG_BLK_ONE);

	dual_block_ram #(
		.DW (`MM_WORD_W),
		.AW (`MM_BLK_AW)
	) u_blk_zero (
		.clk     (REF_CLK),
		.we      (blk0_we),
		.addr    (blk0_addr),
		.wdata   (blk0_wdata),
		.rdata_q (blk0_rdata)
	);

	dual_block_ram #(
		.DW (`MM_WORD_W),
		.AW (`MM_BLK_AW)
	) u_blk_one (
		.clk     (REF_CLK),
		.we      (blk1_we),
		.addr    (DATA_REQ.addr[`MM_BLK_AW-1:0]),
		.wdata   (DATA_REQ.wdata),
		.rdata_q (blk1_rdata)
	);

	////////////////////////////////////////////////////////////////////////////////
	// State update

	assign prog_ext_wr = PROG_REQ.wr && (prog_region == REG_OTHER);
	assign data_ext_wr = DATA_REQ.wr && (data_region == REG_OTHER);

	always_comb begin
		s_d             = s_q;
		s_d.prog_region = prog_region;
		s_d.data_region = data_region;
		s_d.gpio_sync1  = GPIO_PIN_IN;
		s_d.gpio_sync2  = s_q.gpio_sync1;
		s_d.ext_sync1   = EXT_DATA_IN;
		s_d.ext_sync2   = s_q.ext_sync1;
		if (GPIO_CFG_WR) begin
			s_d.gpio_dir = GPIO_DIR_WDATA;
			s_d.gpio_out = GPIO_OUT_WDATA;
		end
		// Program writes win the shared external path
		s_d.ext_oe = prog_ext_wr || data_ext_wr;
		if (prog_ext_wr) begin
			s_d.ext_out = PROG_REQ.wdata;
		end else if (data_ext_wr) begin
			s_d.ext_out = DATA_REQ.wdata;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			s_q             <= '0;
			s_q.prog_region <= REG_OTHER;
			s_q.data_region <= REG_OTHER;
			s_q.gpio_dir    <= `MM_GPIO_RST;
			s_q.gpio_out    <= `MM_GPIO_RST;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	always_comb begin
		unique case (s_q.prog_region)
			REG_RESERVED: PROG_RDATA = `MM_RD_ZERO;
			REG_BOOT:     PROG_RDATA = BOOT_ROM_DATA;
			REG_BLK_ZERO: PROG_RDATA = blk0_rdata;
			default:      PROG_RDATA = s_q.ext_sync2;
		endcase
	end

	always_comb begin
		unique case (s_q.data_region)
			REG_BLK_ZERO: DATA_RDATA = blk0_rdata;
			REG_BLK_ONE:  DATA_RDATA = blk1_rdata;
			default:      DATA_RDATA = s_q.ext_sync2;
		endcase
	end

	assign PROG_REGION   = s_q.prog_region;
	assign DATA_REGION   = s_q.data_region;
	assign BOOT_ROM_SEL  = (prog_region == REG_BOOT) && PROG_REQ.rd;
	assign GPIO_PIN_OUT  = s_q.gpio_out;
	assign GPIO_PIN_OE   = s_q.gpio_dir;
	assign GPIO_LEVEL    = s_q.gpio_sync2;
	assign EXT_WR_STROBE = s_q.ext_oe;

	genvar gi;
	generate
		for (gi = 0; gi < `MM_WORD_W; gi++) begin : g_ext_line
			assign EXT_DATA_OUT[gi] = s_q.ext_out[gi];
			assign EXT_DATA_OE[gi]  = s_q.ext_oe;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);

	a_boot_rom_read: assert property (
		PROG_REQ.rd && BOOT_ROM_ENABLE && in_range(PROG_REQ.addr, `MM_BOOT_LO, `MM_BOOT_HI)
		&& !in_range(PROG_REQ.addr, `MM_RSVD_LO, `MM_RSVD_HI)
		|-> BOOT_ROM_SEL ##1 PROG_RDATA == BOOT_ROM_DATA && PROG_REGION == REG_BOOT)
		else $error("boot ROM window not selected");

	a_reserved_zero: assert property (
		in_range(PROG_REQ.addr, `MM_RSVD_LO, `MM_RSVD_HI)
		|-> !prog_ext_wr && !(BLOCK_ZERO_MAP_SELECT && blk0_we)
		##1 PROG_RDATA == `MM_RD_ZERO && PROG_REGION == REG_RESERVED)
		else $error("reserved program word not held at zero");

	a_blk0_prog_alias: assert property (
		BLOCK_ZERO_MAP_SELECT && PROG_REQ.wr
		&& in_range(PROG_REQ.addr, `MM_P_BLK0_LO, `MM_P_BLK0_HI)
		|-> blk0_we && blk0_addr == PROG_REQ.addr[`MM_BLK_AW-1:0])
		else $error("program alias of block zero missed");

	a_blk0_data_alias: assert property (
		!BLOCK_ZERO_MAP_SELECT && DATA_REQ.wr
		&& in_range(DATA_REQ.addr, `MM_D_BLK0_LO, `MM_D_BLK0_HI)
		|-> blk0_we && blk0_addr == DATA_REQ.addr[`MM_BLK_AW-1:0]
		##1 DATA_REGION == REG_BLK_ZERO && DATA_RDATA == $past(DATA_REQ.wdata))
		else $error("data alias of block zero missed");

	a_blk1_alias: assert property (
		DATA_REQ.wr && in_range(DATA_REQ.addr, `MM_D_BLK1_LO, `MM_D_BLK1_HI)
		&& !(!BLOCK_ZERO_MAP_SELECT && DATA_REQ.addr <= `MM_D_BLK0_HI)
		|=> DATA_RDATA == $past(DATA_REQ.wdata))
		else $error("block one alias lost a write");

	a_gpio_reset: assert property (disable iff (1'b0)
		!RESET_N |=> GPIO_PIN_OE == '0)
		else $error("GPIO driver enabled after reset");

	a_ext_bus_word: assert property (
		prog_ext_wr |=> EXT_DATA_OE == {`MM_WORD_W{1'b1}}
		&& EXT_DATA_OUT == $past(PROG_REQ.wdata))
		else $error("external word not driven on all lines");

	a_map_switch: assert property (
		$changed(BLOCK_ZERO_MAP_SELECT) && DATA_REQ.wr
		&& in_range(DATA_REQ.addr, `MM_D_BLK0_LO, `MM_D_BLK0_HI)
		|-> blk0_we == !BLOCK_ZERO_MAP_SELECT)
		else $error("block zero placement lagged the map select");

	c_boot_read:  cover property (PROG_REQ.rd && prog_region == REG_BOOT);
	c_prog_blk0:  cover property (PROG_REQ.wr && prog_region == REG_BLK_ZERO ##1
		PROG_REQ.rd && prog_region == REG_BLK_ZERO);
	c_map_toggle: cover property ($rose(BLOCK_ZERO_MAP_SELECT) ##[1:8]
		$fell(BLOCK_ZERO_MAP_SELECT));
	c_gpio_out:   cover property (GPIO_CFG_WR && GPIO_DIR_WDATA != '0);

endmodule

// ### pkg/memmap_map.svh
// Purpose: Address map and reset constants of the on-chip memory map decoder
// Assumes: 16-bit program and data address spaces
// Notes:   Definitions only
`ifndef MEMMAP_MAP_SVH
`define MEMMAP_MAP_SVH

`define MM_ADDR_W        16
`define MM_WORD_W        16
`define MM_BLK_AW        8
`define MM_GPIO_COUNT    40
`define MM_BOOT_LO       16'h0000
`define MM_BOOT_HI       16'h00ff
`define MM_RSVD_LO       16'h0040
`define MM_RSVD_HI       16'h0043
`define MM_P_BLK0_LO     16'hfe00
`define MM_P_BLK0_HI     16'hffff
`define MM_D_BLK0_LO     16'h0100
`define MM_D_BLK0_HI     16'h02ff
`define MM_D_BLK1_LO     16'h0300
`define MM_D_BLK1_HI     16'h04ff
`define MM_RD_ZERO       16'h0000
`define MM_GPIO_RST      40'h00_0000_0000

`endif

// ### pkg/memmap_pkg.sv
// Purpose: Types shared by the memory map decoder and its bench
// Assumes: memmap_map.svh holds all numeric constants
// Notes:   State of the decoder is one packed struct
`include "memmap_map.svh"

package memmap_pkg;

	typedef enum logic [2:0] {
		REG_OTHER,
		REG_RESERVED,
		REG_BOOT,
		REG_BLK_ZERO,
		REG_BLK_ONE
	} region_t;

	typedef struct packed {
		logic [`MM_ADDR_W-1:0] addr;
		logic                  rd;
		logic                  wr;
		logic [`MM_WORD_W-1:0] wdata;
	} core_req_t;

	typedef struct packed {
		region_t                   prog_region;
		region_t                   data_region;
		logic [`MM_GPIO_COUNT-1:0] gpio_dir;
		logic [`MM_GPIO_COUNT-1:0] gpio_out;
		logic [`MM_GPIO_COUNT-1:0] gpio_sync1;
		logic [`MM_GPIO_COUNT-1:0] gpio_sync2;
		logic [`MM_WORD_W-1:0]     ext_sync1;
		logic [`MM_WORD_W-1:0]     ext_sync2;
		logic [`MM_WORD_W-1:0]     ext_out;
		logic                      ext_oe;
	} dec_state_t;

endpackage

// ### rtl/dual_block_ram.sv
// Purpose: One dual-access RAM block, one write and one registered read per cycle
// Assumes: Address and write come from the decoder on the same clock
// Notes:   Read data appear one edge after the address
`timescale 1ns/1ps

module dual_block_ram #(
	parameter int DW = 16,
	parameter int AW = 8
) (
	input  wire logic          clk,
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [DW-1:0] wdata,
	output logic      [DW-1:0] rdata_q
);

	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata_q <= we ? wdata : mem[addr];
	end

endmodule

// ### verif/boot_rom_model.sv
// Purpose: Boot ROM stand-in answering program reads in the boot window
// Assumes: Word is registered on the request edge and held for the next cycle
// Notes:   Outside a selected read the word toggles so a stale value never matches
`timescale 1ns/1ps

module boot_rom_model (
	input  wire logic        clk,
	input  wire logic        sel,
	input  wire logic [15:0] addr,
	output logic      [15:0] data
);
	always_ff @(posedge clk) begin
		data <= sel ? {8'hb0, addr[7:0]} : ~data;
	end
endmodule

// ### verif/test_onchip_memory_map_decoder.sv
// Purpose: Self-checking bench of the memory map decoder
// Assumes: Requests change at the falling edge, results sampled after the rising edge
// Notes:   Random data from a fixed xorshift seed
`timescale 1ns/1ps
`include "memmap_map.svh"

module test_onchip_memory_map_decoder
	import memmap_pkg::*;
;
	logic                      clk = 1'h0;
	logic                      rst_n = 1'h0;
	core_req_t                 prog_req, data_req;
	logic                      boot_en, map_sel, boot_v, sel_v, cfg_wr, boot_sel, ext_stb;
	logic [`MM_WORD_W-1:0]     boot_data, prog_rdata, data_rdata, ext_in, ext_out, ext_oe;
	region_t                   prog_region, data_region;
	logic [`MM_GPIO_COUNT-1:0] dir_w, out_w, pin_in, pin_out, pin_oe, level, lv;
	logic [31:0]               seed = 32'hbb0b;
	int                        miscompares = 0;
	int                        tests_run = 0;
	int                        i;
	logic [15:0]               w, a, ext_v;
	logic [7:0]                k;

	always #10 clk = ~clk;

	onchip_memory_map_decoder i_onchip_memory_map_decoder (
		.REF_CLK(clk), .RESET_N(rst_n), .PROG_REQ(prog_req), .DATA_REQ(data_req),
		.BOOT_ROM_ENABLE(boot_en), .BLOCK_ZERO_MAP_SELECT(map_sel),
		.BOOT_ROM_DATA(boot_data), .PROG_RDATA(prog_rdata), .DATA_RDATA(data_rdata),
		.PROG_REGION(prog_region), .DATA_REGION(data_region), .BOOT_ROM_SEL(boot_sel),
		.GPIO_CFG_WR(cfg_wr), .GPIO_DIR_WDATA(dir_w), .GPIO_OUT_WDATA(out_w),
		.GPIO_PIN_IN(pin_in), .GPIO_PIN_OUT(pin_out), .GPIO_PIN_OE(pin_oe),
		.GPIO_LEVEL(level), .EXT_DATA_IN(ext_in), .EXT_DATA_OUT(ext_out),
		.EXT_DATA_OE(ext_oe), .EXT_WR_STROBE(ext_stb)
	);

	boot_rom_model i_boot_rom_model (
		.clk(clk), .sel(boot_sel), .addr(prog_req.addr), .data(boot_data)
	);

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic core_req_t rq(input logic r, input logic wr, input logic [15:0] ad,
		input logic [15:0] wd);
		return '{addr: ad, rd: r, wr: wr, wdata: wd};
	endfunction

	function automatic logic [15:0] boot_word(input logic [15:0] ad);
		return (ad >= `MM_RSVD_LO && ad <= `MM_RSVD_HI) ? 16'h0000 : {8'hb0, ad[7:0]};
	endfunction

	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("Comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// One request cycle; results are read 1 ns after the taking edge
	task automatic cyc(input core_req_t p, input core_req_t d);
		@(negedge clk);
		prog_req = p;
		data_req = d;
		map_sel = sel_v;
		boot_en = boot_v;
		pin_in = 40'({xs(), xs()});
		ext_in = ext_v;
		@(posedge clk);
		#1;
	endtask

	task automatic rw(input logic ps, input logic [15:0] wa, input logic [15:0] ra,
		input logic [15:0] wd);
		if (ps) begin
			cyc(rq(1'h0, 1'h1, wa, wd), '0);
			cyc(rq(1'h1, 1'h0, ra, 16'h0000), '0);
		end else begin
			cyc('0, rq(1'h0, 1'h1, wa, wd));
			cyc('0, rq(1'h1, 1'h0, ra, 16'h0000));
		end
	endtask

	task automatic do_reset();
		@(negedge clk);
		rst_n = 1'h0;
		repeat (2) @(negedge clk);
		chk(pin_oe, 40'h0);
		chk(pin_out, 40'h0);
		rst_n = 1'h1;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		prog_req = '0;
		data_req = '0;
		{boot_en, map_sel, boot_v, sel_v, cfg_wr} = 5'h00;
		{dir_w, out_w, pin_in} = '0;
		{ext_in, ext_v} = 32'h0;
		do_reset();
		for (i = 0; i < 8; i++) begin
			k = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'(xs());
			w = 16'(xs());
			rw(1'h0, 16'h0100 + k, 16'h0200 + k, w);
			chk(data_rdata, w);
			sel_v = 1'(xs());
			w = 16'(xs());
			rw(1'h0, 16'h0400 + k, 16'h0300 + k, w);
			chk(data_rdata, w);
			sel_v = 1'h1;
			w = 16'(xs());
			rw(1'h1, (i[0] ? 16'hff00 : 16'hfe00) + k, (i[0] ? 16'hfe00 : 16'hff00) + k, w);
			chk(prog_rdata, w);
			sel_v = 1'h0;
		end
		w = 16'(xs());
		cyc('0, rq(1'h0, 1'h1, 16'h0110, w));
		sel_v = 1'h1;
		cyc(rq(1'h1, 1'h0, 16'hfe10, 16'h0000), rq(1'h1, 1'h0, 16'h0210, 16'h0000));
		chk(40'(data_region), 40'(REG_OTHER));
		chk(40'(prog_region), 40'(REG_BLK_ZERO));
		chk(prog_rdata, w);
		sel_v = 1'h0;
		cyc(rq(1'h1, 1'h0, 16'hfe10, 16'h0000), rq(1'h1, 1'h0, 16'h0210, 16'h0000));
		chk(data_rdata, w);
		chk(40'(prog_region), 40'(REG_OTHER));
		boot_v = 1'h1;
		for (i = 0; i < 12; i++) begin
			a = (i < 4) ? 16'h0040 + 16'(i) : (i == 4) ? 16'h00ff : 16'(xs()) & 16'h00ff;
			boot_v = (i >= 4) || i[0];
			cyc(rq(1'h0, 1'h1, a, 16'(xs())), '0);
			chk(ext_stb, 1'h0);
			cyc(rq(1'h1, 1'h0, a, 16'h0000), '0);
			chk(boot_sel, boot_v && boot_word(a) != 16'h0000);
			chk(prog_rdata, boot_word(a));
		end
		boot_v = 1'h0;
		for (i = 0; i < 3; i++) begin
			w = (i == 0) ? 16'h8000 : 16'(xs());
			if (i == 1)
				cyc(rq(1'h0, 1'h1, 16'h8000, w), rq(1'h0, 1'h1, 16'h8000, ~w));
			else
				cyc('0, rq(1'h0, 1'h1, 16'h8000, w));
			chk(ext_out, w);
			chk(ext_oe, 16'hffff);
			chk(ext_stb, 1'h1);
			ext_v = 16'(xs());
			repeat (4) cyc('0, '0);
			chk(ext_oe, 16'h0000);
			chk(ext_stb, 1'h0);
			cyc('0, rq(1'h1, 1'h0, 16'h8000, 16'h0000));
			chk(data_rdata, ext_v);
		end
		@(negedge clk);
		dir_w = '1;
		out_w = 40'({xs(), xs()});
		cfg_wr = 1'h1;
		@(negedge clk);
		cfg_wr = 1'h0;
		cyc('0, '0);
		lv = pin_in;
		cyc('0, '0);
		chk(level, lv);
		chk(pin_oe, dir_w);
		chk(pin_out, out_w);
		do_reset();
		cyc('0, '0);
		chk(pin_oe, 40'h0);
		test_done();
	end

	initial begin
		#(20 * 3000);
		miscompares++;
		test_done();
	end
endmodule
